// [logic/pcm_bank.sv]
// Purpose: APB bank of read-only mirrors of configuration-space values
// Assumes: core values arrive on i_mclk; APB slave with zero wait states
// Notes:   mirrors trail the core by one cycle; a read shows the value
//          held at its setup edge, so software sees at most two cycles
//          of lag; writes to any mirror are refused with pslverr
`timescale 1ns/1ps
`default_nettype none

`include "pcm_map.svh"

module pcm_bank
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_n,
  // apb slave
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [`PCM_ADDR_W-1:0]       i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  input  wire logic [3:0]                   i_pstrb,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  // core port mode, high for root port
  input  wire logic                         i_root_port,
  // configuration values from the core
  input  wire logic [`PCM_PREF_LIM_W-1:0]   i_prefetch_limit_upper,
  input  wire logic [`PCM_PM_CS_W-1:0]      i_power_mgmt_ctrl_status,
  input  wire logic [`PCM_MSG_CTRL_W-1:0]   i_msix_message_control,
  input  wire logic [`PCM_MSG_CTRL_W-1:0]   i_msi_message_control,
  input  wire logic [`PCM_TC_VC_MAP_W-1:0]  i_traffic_class_channel_map,
  input  wire logic [`PCM_MSI_DATA_W-1:0]   i_msi_message_data,
  input  wire logic [`PCM_BUS_DEV_W-1:0]    i_bus_device_number,
  input  wire logic [`PCM_LTSSM_W-1:0]      i_link_training_state,
  // mirrored values to application logic
  output logic      [`PCM_PREF_LIM_W-1:0]   o_prefetch_limit_upper,
  output logic      [`PCM_PM_CS_W-1:0]      o_power_mgmt_ctrl_status,
  output logic      [`PCM_MSG_CTRL_W-1:0]   o_msix_message_control,
  output logic      [`PCM_MSG_CTRL_W-1:0]   o_msi_message_control,
  output logic      [`PCM_TC_VC_MAP_W-1:0]  o_traffic_class_channel_map,
  output logic      [`PCM_MSI_DATA_W-1:0]   o_msi_message_data,
  output logic      [`PCM_BUS_DEV_W-1:0]    o_bus_device_number,
  output logic      [`PCM_LTSSM_W-1:0]      o_link_training_state
);

  ////////////////////////////////////////////////////////////////////////////
  // mirror stages

  // sources after the mode and class-zero fixes, then the held copies
  logic [`PCM_PREF_LIM_W-1:0]  pref_src;
  logic [`PCM_TC_VC_MAP_W-1:0] map_src;
  logic [`PCM_PREF_LIM_W-1:0]  pref_q;
  logic [`PCM_PM_CS_W-1:0]     pm_q;
  logic [`PCM_MSG_CTRL_W-1:0]  msix_q;
  logic [`PCM_MSG_CTRL_W-1:0]  msi_q;
  logic [`PCM_TC_VC_MAP_W-1:0] map_q;
  logic [`PCM_MSI_DATA_W-1:0]  data_q;
  logic [`PCM_BUS_DEV_W-1:0]   busdev_q;
  logic [`PCM_LTSSM_W-1:0]     ltssm_q;
  pcm_chg_t                    chg_pulse;
  pcm_mode_t                   mode;

  // the mode pin is core logic on this clock, so it is used directly
  assign mode = pcm_mode_t'(i_root_port);

  // endpoint cores have no bridge header, so the limit is held at zero
  assign pref_src = (mode == PCM_MODE_ROOT_PORT) ?
                    i_prefetch_limit_upper : '0;

  // class zero maps to channel zero whatever the core drives
  assign map_src = {i_traffic_class_channel_map[`PCM_TC_VC_MAP_W-1:
                                                `PCM_TC0_MSB+1],
                    3'h0};

  // each change pulse lands on its own bit of the changed register, so
  // the indices below must follow the bit order of that register

  // prefetchable limit upper bits
  pcm_mirror #(.W(`PCM_PREF_LIM_W)) u_pref (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (pref_src),
    .o_value   (pref_q),
    .o_changed (chg_pulse[`PCM_CHG_PREF_LIM])
  );

  // power management control and status word
  pcm_mirror #(.W(`PCM_PM_CS_W)) u_pm (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_power_mgmt_ctrl_status),
    .o_value   (pm_q),
    .o_changed (chg_pulse[`PCM_CHG_PM_CS])
  );

  // msi-x message control
  pcm_mirror #(.W(`PCM_MSG_CTRL_W)) u_msix (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_msix_message_control),
    .o_value   (msix_q),
    .o_changed (chg_pulse[`PCM_CHG_MSIX_CTRL])
  );

  // msi message control
  pcm_mirror #(.W(`PCM_MSG_CTRL_W)) u_msi (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_msi_message_control),
    .o_value   (msi_q),
    .o_changed (chg_pulse[`PCM_CHG_MSI_CTRL])
  );

  // traffic class to channel map
  pcm_mirror #(.W(`PCM_TC_VC_MAP_W)) u_map (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (map_src),
    .o_value   (map_q),
    .o_changed (chg_pulse[`PCM_CHG_TC_VC_MAP])
  );

  // msi message data
  pcm_mirror #(.W(`PCM_MSI_DATA_W)) u_data (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_msi_message_data),
    .o_value   (data_q),
    .o_changed (chg_pulse[`PCM_CHG_MSI_DATA])
  );

  // bus and device number
  pcm_mirror #(.W(`PCM_BUS_DEV_W)) u_busdev (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_bus_device_number),
    .o_value   (busdev_q),
    .o_changed (chg_pulse[`PCM_CHG_BUS_DEV])
  );

  // link training state, refreshed every cycle
  pcm_mirror #(.W(`PCM_LTSSM_W)) u_ltssm (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_value   (i_link_training_state),
    .o_value   (ltssm_q),
    .o_changed (chg_pulse[`PCM_CHG_LTSSM])
  );

  // mirrors leave the block straight from their flip-flops
  assign o_prefetch_limit_upper      = pref_q;
  assign o_power_mgmt_ctrl_status    = pm_q;
  assign o_msix_message_control      = msix_q;
  assign o_msi_message_control       = msi_q;
  assign o_traffic_class_channel_map = map_q;
  assign o_msi_message_data          = data_q;
  assign o_bus_device_number         = busdev_q;
  assign o_link_training_state       = ltssm_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup_phase;
  logic access_phase;
  logic hit_pref;
  logic hit_pm;
  logic hit_msix;
  logic hit_msi;
  logic hit_map;
  logic hit_data;
  logic hit_busdev;
  logic hit_ltssm;
  logic hit_sel;
  logic hit_vc;
  logic hit_chg;
  logic hit_mode;
  logic hit_ro;
  logic hit_any;
  logic wr_ok;
  logic wr_err;
  logic rd_setup;
  logic wr_sel;
  logic wr_chg;

  // bus phases; read data is captured in the setup cycle
  assign setup_phase  = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign rd_setup     = setup_phase & ~i_pwrite;

  // the full address is compared, so no word has an alias and a
  // misaligned access is simply unmapped
  assign hit_pref   = (i_paddr == `PCM_OFF_PREF_LIM);
  assign hit_pm     = (i_paddr == `PCM_OFF_PM_CS);
  assign hit_msix   = (i_paddr == `PCM_OFF_MSIX_CTRL);
  assign hit_msi    = (i_paddr == `PCM_OFF_MSI_CTRL);
  assign hit_map    = (i_paddr == `PCM_OFF_TC_VC_MAP);
  assign hit_data   = (i_paddr == `PCM_OFF_MSI_DATA);
  assign hit_busdev = (i_paddr == `PCM_OFF_BUS_DEV);
  assign hit_ltssm  = (i_paddr == `PCM_OFF_LTSSM);
  assign hit_sel    = (i_paddr == `PCM_OFF_LOOKUP_SEL);
  assign hit_vc     = (i_paddr == `PCM_OFF_LOOKUP_VC);
  assign hit_chg    = (i_paddr == `PCM_OFF_CHANGED);
  assign hit_mode   = (i_paddr == `PCM_OFF_MODE);

  // mirrors, lookup result and mode cannot be written
  assign hit_ro  = hit_pref | hit_pm | hit_msix | hit_msi | hit_map |
                   hit_data | hit_busdev | hit_ltssm | hit_vc | hit_mode;
  assign hit_any = hit_ro | hit_sel | hit_chg;

  // a write lands only on the two writable words; writes to a mirror
  // are dropped and flagged so software sees its mistake
  assign wr_ok  = access_phase & i_pwrite & (hit_sel | hit_chg);
  assign wr_err = i_pwrite & hit_ro;

  // lane 0 carries both writable fields, so it gates the strobes
  assign wr_sel = wr_ok & hit_sel & i_pstrb[0];
  assign wr_chg = wr_ok & hit_chg & i_pstrb[0];

  ////////////////////////////////////////////////////////////////////////////
  // lookup select and change flags

  pcm_tc_t  lookup_tc;
  pcm_tc_t  next_lookup_tc;
  pcm_vc_t  lookup_vc;
  pcm_chg_t changed;
  pcm_chg_t next_changed;
  pcm_chg_t chg_clear;

  // only byte lane 0 holds the select, so other lanes are ignored
  assign next_lookup_tc = wr_sel ? i_pwdata[`PCM_TC_W-1:0] : lookup_tc;

  // same lookup that packet builders do on the map port; the select is
  // three bits wide, so every class has a field and none is out of range
  assign lookup_vc = map_q[lookup_tc*`PCM_VC_W +: `PCM_VC_W];

  // write one to clear; a change in the same cycle keeps its flag set,
  // so software never loses a change that raced its own clear
  assign chg_clear    = wr_chg ? i_pwdata[`PCM_NUM_MIRRORS-1:0] : '0;
  assign next_changed = (changed & ~chg_clear) | chg_pulse;

  // select and sticky flags, both cleared with the mirrors
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      lookup_tc <= `PCM_RST_LOOKUP_SEL;
      changed   <= `PCM_RST_CHANGED;
    end else begin
      lookup_tc <= next_lookup_tc;
      changed   <= next_changed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and response

  logic [31:0] rd_word;
  logic [31:0] next_prdata;
  logic [31:0] rd_pref;
  logic [31:0] rd_pm;
  logic [31:0] rd_msix;
  logic [31:0] rd_msi;
  logic [31:0] rd_map;
  logic [31:0] rd_data;
  logic [31:0] rd_busdev;
  logic [31:0] rd_ltssm;
  logic [31:0] rd_sel;
  logic [31:0] rd_vc;
  logic [31:0] rd_chg;
  logic [31:0] rd_mode;
  logic        err_unmapped;
  logic        err_ro_write;

  // narrow values sit in the low bits, the rest read zero
  assign rd_pref   = {20'h0, pref_q};
  assign rd_pm     = pm_q;
  assign rd_msix   = {16'h0, msix_q};
  assign rd_msi    = {16'h0, msi_q};
  assign rd_map    = {8'h0, map_q};
  assign rd_data   = {16'h0, data_q};
  assign rd_busdev = {19'h0, busdev_q};
  assign rd_ltssm  = {27'h0, ltssm_q};
  assign rd_sel    = {29'h0, lookup_tc};
  assign rd_vc     = {29'h0, lookup_vc};
  assign rd_chg    = {24'h0, changed};
  assign rd_mode   = {31'h0, mode == PCM_MODE_ROOT_PORT};

  // at most one address matches, so the order of the chain is free;
  // an unmapped address falls through to zero
  assign rd_word =
    hit_pref   ? rd_pref   :
    hit_pm     ? rd_pm     :
    hit_msix   ? rd_msix   :
    hit_msi    ? rd_msi    :
    hit_map    ? rd_map    :
    hit_data   ? rd_data   :
    hit_busdev ? rd_busdev :
    hit_ltssm  ? rd_ltssm  :
    hit_sel    ? rd_sel    :
    hit_vc     ? rd_vc     :
    hit_chg    ? rd_chg    :
    hit_mode   ? rd_mode   :
                 32'h0000_0000;

  // data is captured in the setup cycle so it comes from a flip-flop
  // in the access cycle; mirrors may move between the two, which is
  // harmless since every read already shows a one-cycle-old value
  assign next_prdata = rd_setup ? rd_word : o_prdata;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata <= `PCM_RST_MIRROR;
    end else begin
      o_prdata <= next_prdata;
    end
  end

  // an access to no register, or a write to a read-only word, is
  // answered with an error; the word itself is left untouched
  assign err_unmapped = access_phase & ~hit_any;
  assign err_ro_write = access_phase & wr_err;

  // zero wait states
  assign o_pready  = 1'b1;
  assign o_pslverr = err_unmapped | err_ro_write;

endmodule : pcm_bank

`default_nettype wire

// [logic/pcm_map.svh]
// Purpose: offsets, field positions, widths and reset values of the mirror
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by the mirror bank and its package users
`ifndef PCM_MAP_SVH
`define PCM_MAP_SVH

// apb address width and register byte offsets
`define PCM_ADDR_W          12
`define PCM_OFF_PREF_LIM    12'h000
`define PCM_OFF_PM_CS       12'h004
`define PCM_OFF_MSIX_CTRL   12'h008
`define PCM_OFF_MSI_CTRL    12'h00C
`define PCM_OFF_TC_VC_MAP   12'h010
`define PCM_OFF_MSI_DATA    12'h014
`define PCM_OFF_BUS_DEV     12'h018
`define PCM_OFF_LTSSM       12'h01C
`define PCM_OFF_LOOKUP_SEL  12'h020
`define PCM_OFF_LOOKUP_VC   12'h024
`define PCM_OFF_CHANGED     12'h028
`define PCM_OFF_MODE        12'h02C

// field widths
`define PCM_PREF_LIM_W      12
`define PCM_PM_CS_W         32
`define PCM_MSG_CTRL_W      16
`define PCM_TC_VC_MAP_W     24
`define PCM_MSI_DATA_W      16
`define PCM_BUS_DEV_W       13
`define PCM_LTSSM_W         5
`define PCM_VC_W            3
`define PCM_TC_W            3
`define PCM_NUM_MIRRORS     8

// field positions
`define PCM_PM_CTRL_LSB     16
`define PCM_PM_CTRL_MSB     31
`define PCM_PM_STAT_LSB     0
`define PCM_PM_STAT_MSB     15
`define PCM_BUS_NUM_LSB     5
`define PCM_BUS_NUM_MSB     12
`define PCM_DEV_NUM_LSB     0
`define PCM_DEV_NUM_MSB     4
`define PCM_TC0_LSB         0
`define PCM_TC0_MSB         2

// change flag bit positions in the changed register
`define PCM_CHG_PREF_LIM    0
`define PCM_CHG_PM_CS       1
`define PCM_CHG_MSIX_CTRL   2
`define PCM_CHG_MSI_CTRL    3
`define PCM_CHG_TC_VC_MAP   4
`define PCM_CHG_MSI_DATA    5
`define PCM_CHG_BUS_DEV     6
`define PCM_CHG_LTSSM       7

// reset values
`define PCM_RST_MIRROR      32'h0000_0000
`define PCM_RST_LOOKUP_SEL  3'h0
`define PCM_RST_CHANGED     8'h00

`endif

// [logic/pcm_mirror.sv]
// Purpose: one mirrored configuration value with change detection
// Assumes: source value is on i_mclk, so no synchroniser is needed
// Notes:   follows the source one cycle late, clears to zero on reset
`timescale 1ns/1ps
`default_nettype none

module pcm_mirror #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // source value from the core
  input  wire logic [W-1:0] i_value,
  // mirrored value and change pulse
  output logic      [W-1:0] o_value,
  output logic              o_changed
);

  logic [W-1:0] next_value;
  logic         next_changed;

  // compare against the held copy, pulse once per change
  assign next_value   = i_value;
  assign next_changed = (i_value != o_value);

  // capture every cycle so the copy never goes stale
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_value   <= '0;
      o_changed <= 1'b0;
    end else begin
      o_value   <= next_value;
      o_changed <= next_changed;
    end
  end

endmodule : pcm_mirror

`default_nettype wire

// [logic/pcm_pkg.sv]
// Purpose: shared types of the configuration mirror bank
// Assumes: constants live in pcm_map.svh
// Notes:   types only
`include "pcm_map.svh"

package pcm_pkg;

  // apb byte address
  typedef logic [`PCM_ADDR_W-1:0]      pcm_addr_t;
  // one virtual channel number and one traffic class number
  typedef logic [`PCM_VC_W-1:0]        pcm_vc_t;
  typedef logic [`PCM_TC_W-1:0]        pcm_tc_t;
  // sticky change flags, one per mirrored value
  typedef logic [`PCM_NUM_MIRRORS-1:0] pcm_chg_t;
  // port mode of the core
  typedef enum logic [0:0] {
    PCM_MODE_ENDPOINT  = 1'b0,
    PCM_MODE_ROOT_PORT = 1'b1
  } pcm_mode_t;

endpackage : pcm_pkg

// [tb/pcm_app_model.sv]
// Purpose: application side picking a channel for an outgoing packet
// Assumes: map comes from the mirror bank on the same clock
// Notes:   stateless lookup, so it answers in the same cycle
`timescale 1ns/1ps
`default_nettype none

module pcm_app_model
  import pcm_pkg::*;
(
  // mirrored class map and class of the packet
  input  wire logic [23:0] i_map,
  input  wire pcm_tc_t     i_tc,
  // chosen virtual channel
  output var  pcm_vc_t     o_vc
);
  // the packet's class indexes its 3-bit field of the map
  assign o_vc = i_map[3*i_tc +: 3];
endmodule : pcm_app_model

`default_nettype wire

// [tb/pcm_bank_asserts.sv]
// Purpose: port-level checks on the configuration mirror bank
// Assumes: one clock, synchronous active-low reset
// Notes:   mirrors are compared with the inputs one cycle earlier
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"

module pcm_bank_asserts (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  // core values and mirrors
  input wire logic        i_root_port,
  input wire logic [11:0] i_prefetch_limit_upper,
  input wire logic [11:0] o_prefetch_limit_upper,
  input wire logic [31:0] i_power_mgmt_ctrl_status,
  input wire logic [31:0] o_power_mgmt_ctrl_status,
  input wire logic [15:0] i_msi_message_control,
  input wire logic [15:0] o_msi_message_control,
  input wire logic [23:0] i_traffic_class_channel_map,
  input wire logic [23:0] o_traffic_class_channel_map,
  input wire logic [15:0] i_msi_message_data,
  input wire logic [15:0] o_msi_message_data,
  input wire logic [12:0] i_bus_device_number,
  input wire logic [12:0] o_bus_device_number,
  input wire logic [4:0]  i_link_training_state,
  input wire logic [4:0]  o_link_training_state
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // read setup of the link state word followed by its access cycle
  sequence s_rd_ltssm;
    i_psel && !i_penable && !i_pwrite && i_paddr == `PCM_OFF_LTSSM
    ##1 i_psel && i_penable;
  endsequence

  // $past guard keeps the first edge after reset from comparing stale data
  a_reset_clear: assert property (
    !$past(i_rst_n) |-> o_power_mgmt_ctrl_status == 32'h0
      && o_link_training_state == 5'h0) else $error("mirror not cleared");
  a_prefetch_mode: assert property (
    $past(i_rst_n) |-> o_prefetch_limit_upper == ($past(i_root_port)
      ? $past(i_prefetch_limit_upper) : 12'h000))
    else $error("prefetch limit wrong");
  a_power_word: assert property (
    $past(i_rst_n) |-> o_power_mgmt_ctrl_status
      == $past(i_power_mgmt_ctrl_status)) else $error("power word wrong");
  a_msi_data: assert property (
    $past(i_rst_n) |-> o_msi_message_data == $past(i_msi_message_data))
    else $error("msi data wrong");
  a_tc_zero: assert property (
    o_traffic_class_channel_map[2:0] == 3'h0) else $error("class zero set");
  a_tc_fields: assert property (
    $past(i_rst_n) |-> o_traffic_class_channel_map
      == ($past(i_traffic_class_channel_map) & 24'hFFFFF8))
    else $error("class map wrong");
  a_bus_dev: assert property (
    $past(i_rst_n) |-> o_bus_device_number == $past(i_bus_device_number))
    else $error("bus device wrong");
  a_ltssm_track: assert property (
    $past(i_rst_n) |-> o_link_training_state == $past(i_link_training_state))
    else $error("link state stale");
  a_ltssm_read: assert property (
    s_rd_ltssm |-> o_prdata == {27'h0, $past(o_link_training_state)})
    else $error("link state read wrong");
  a_msg_ctrl: assert property (
    $past(i_rst_n) |-> o_msi_message_control == $past(i_msi_message_control))
    else $error("msi control wrong");
  a_write_refused: assert property (
    i_psel && i_penable && i_pwrite && i_paddr <= `PCM_OFF_LTSSM
      |-> o_pslverr) else $error("mirror write accepted");
endmodule : pcm_bank_asserts

bind pcm_bank pcm_bank_asserts u_chk (.*);

`default_nettype wire

// [tb/pcm_bank_tb.sv]
// Purpose: apb-driven check of the configuration mirror bank
// Assumes: zero-wait slave, mirrors one cycle behind the core
// Notes:   expected words are built from the field layout
`timescale 1ns/1ps
`default_nettype none
`include "pcm_map.svh"

module pcm_bank_tb
  import pcm_pkg::*;
;
  logic        i_mclk, i_rst_n, i_psel, i_penable, i_pwrite, i_root_port;
  logic        o_pready, o_pslverr, er;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0]  i_pstrb;
  logic [11:0] i_prefetch_limit_upper, o_prefetch_limit_upper;
  logic [31:0] i_power_mgmt_ctrl_status, o_power_mgmt_ctrl_status;
  logic [15:0] i_msix_message_control, o_msix_message_control;
  logic [15:0] i_msi_message_control, o_msi_message_control;
  logic [23:0] i_traffic_class_channel_map, o_traffic_class_channel_map;
  logic [15:0] i_msi_message_data, o_msi_message_data;
  logic [12:0] i_bus_device_number, o_bus_device_number;
  logic [4:0]  i_link_training_state, o_link_training_state;
  pcm_tc_t     tc;
  pcm_vc_t     vc;
  int          errors, n_tests;
  logic [31:0] exp_val [8];

  pcm_bank dut (.*);
  pcm_app_model u_app (.i_map(o_traffic_class_channel_map), .i_tc(tc),
                       .o_vc(vc));

  // 20 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // one apb transfer; the wait on pready is bounded, a hang ends the run
  task automatic apb(input logic wr, input pcm_addr_t a,
                     input logic [31:0] wd);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    for (int k = 0; k <= 20; k++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
      if (k == 20) begin
        errors++;
        test_done();
      end
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_root_port} = '0;
    i_paddr = '0;
    i_pwdata = '0;
    i_pstrb = 4'hF;
    tc = '0;
    {i_prefetch_limit_upper, i_power_mgmt_ctrl_status} = '0;
    {i_msix_message_control, i_msi_message_control} = '0;
    {i_traffic_class_channel_map, i_msi_message_data} = '0;
    {i_bus_device_number, i_link_training_state} = '0;
    errors = 0;
    n_tests = 0;
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, pcm_addr_t'(4 * r), '0);
      chk("reset word", rd, 32'h0);
    end
    // distinct values; class zero field loaded nonzero on purpose
    i_root_port <= 1'b1;
    i_prefetch_limit_upper <= 12'hABC;
    i_power_mgmt_ctrl_status <= 32'h1234_5678;
    i_msix_message_control <= 16'hC001;
    i_msi_message_control <= 16'h00A5;
    i_traffic_class_channel_map <= 24'hFAC68F;
    i_msi_message_data <= 16'h5A3C;
    i_bus_device_number <= {8'hF9, 5'h1B};
    i_link_training_state <= 5'h11;
    exp_val = '{32'hABC, 32'h1234_5678, 32'hC001, 32'hA5, 32'hFAC688,
                32'h5A3C, 32'h1F3B, 32'h11};
    repeat (2) @(posedge i_mclk);
    for (int r = 0; r < 8; r++) begin
      apb(1'b0, pcm_addr_t'(4 * r), '0);
      chk("mirror word", rd, exp_val[r]);
      chk("read error", er, 32'h0);
    end
    chk("pm control", o_power_mgmt_ctrl_status[31:16], 32'h1234);
    chk("bus number", o_bus_device_number[12:5], 32'hF9);
    chk("device number", o_bus_device_number[4:0], 32'h1B);
    chk("msix port", o_msix_message_control, 32'hC001);
    apb(1'b0, `PCM_OFF_MODE, '0);
    chk("root mode", rd, 32'h1);
    apb(1'b0, `PCM_OFF_CHANGED, '0);
    chk("change flags", rd, 32'hFF);
    apb(1'b1, `PCM_OFF_CHANGED, 32'hFF);
    apb(1'b0, `PCM_OFF_CHANGED, '0);
    chk("flags cleared", rd, 32'h0);
    // a change racing its own clear keeps its flag
    fork
      apb(1'b1, `PCM_OFF_CHANGED, 32'hFF);
      begin
        @(posedge i_mclk);
        i_msi_message_data <= 16'h0F0F;
      end
    join
    chk("clear write ok", er, 32'h0);
    apb(1'b0, `PCM_OFF_CHANGED, '0);
    chk("set beats clear", rd, 32'h20);
    apb(1'b1, `PCM_OFF_PM_CS, 32'hFFFF_FFFF);
    chk("write refused", er, 32'h1);
    apb(1'b0, `PCM_OFF_PM_CS, '0);
    chk("pm unchanged", rd, 32'h1234_5678);
    apb(1'b1, `PCM_OFF_LOOKUP_VC, 32'h7);
    chk("vc write refused", er, 32'h1);
    apb(1'b1, `PCM_OFF_MODE, 32'h0);
    chk("mode write refused", er, 32'h1);
    apb(1'b0, 12'hFF0, '0);
    chk("unmapped error", er, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // every class through the bank lookup and the application model
    for (int t = 0; t < 8; t++) begin
      tc <= pcm_tc_t'(t);
      apb(1'b1, `PCM_OFF_LOOKUP_SEL, 32'(t));
      apb(1'b0, `PCM_OFF_LOOKUP_SEL, '0);
      chk("lookup sel", rd, 32'(t));
      apb(1'b0, `PCM_OFF_LOOKUP_VC, '0);
      chk("lookup vc", rd, 32'(exp_val[4][3 * t +: 3]));
      chk("app vc", 32'(vc), 32'(exp_val[4][3 * t +: 3]));
    end
    // a select write without lane 0 leaves the select alone
    i_pstrb <= 4'hE;
    apb(1'b1, `PCM_OFF_LOOKUP_SEL, 32'h0);
    i_pstrb <= 4'hF;
    apb(1'b0, `PCM_OFF_LOOKUP_SEL, '0);
    chk("lane 0 gate", rd, 32'h7);
    i_root_port <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("endpoint limit", o_prefetch_limit_upper, 32'h0);
    apb(1'b0, `PCM_OFF_PREF_LIM, '0);
    chk("endpoint word", rd, 32'h0);
    apb(1'b0, `PCM_OFF_MODE, '0);
    chk("endpoint mode", rd, 32'h0);
    for (int s = 1; s < 32; s += 10) begin
      i_link_training_state <= 5'(s);
      repeat (2) @(posedge i_mclk);
      chk("link state", o_link_training_state, 32'(s));
    end
    // limit, msi data and link state moved since the clear
    apb(1'b0, `PCM_OFF_CHANGED, '0);
    chk("change bits", rd, 32'hA1);
    // second reset in mid-run, then reload
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk("reset power word", o_power_mgmt_ctrl_status, 32'h0);
    chk("reset map", o_traffic_class_channel_map, 32'h0);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("reload power", o_power_mgmt_ctrl_status, 32'h1234_5678);
    test_done();
  end
endmodule : pcm_bank_tb

`default_nettype wire
